// ### shared/rx_link_consts.vh
/*
  constants for the receive link initialisation block: character codes,
  counts, frame length and fifo sizes. assumes inclusion by bare name.
*/
`ifndef RX_LINK_CONSTS_VH
`define RX_LINK_CONSTS_VH

`define CHAR_K            8'hbc
`define CHAR_R            8'h1c
`define CHAR_A            8'h7c
`define CHAR_Q            8'h9c
`define K_COUNT_NEEDED    3'h4
`define ILAS_MULTIFRAMES  3'h4
`define CFG_MULTIFRAME    3'h2
`define DEFAULT_FRAME_LEN 8'h20
`define FIFO_WIDTH        8
`define FIFO_DEPTH        16

`endif

// ### src/rx_link_init.v
/*
  receive link initialisation for one lane: code group sync, alignment
  sequence tracking, config capture and user data streaming through a fifo.
  assumes an 8b/10b decoded character stream on mclk and a single device.
*/
// Function
// - each received character arrives with valid, control, code error and disparity error flags.
// - sync proceeds only out of reset with clock recovery locked and valid characters arriving.
// - a character is usable only with no decode error and no disparity error.
// - after four consecutive K characters the active-low sync request goes high.
// - an R character following the K characters starts the alignment sequence.
// - link configuration is taken from the second multiframe of the alignment sequence.
// - with one device the all-devices aligned flag is loaded from the same data-phase test as the device aligned flag, in the same cycle.
// - after the alignment sequence ends the link streams user data to the transport layer.
// - the sysref input is used only in subclass 1.
// - status, alignment, sync request and interrupt outputs are all on the link clock.
// - in user data phase the transport output carries the converter samples.
// - normal operation needs lock high and calibration busy and both resets low.
`timescale 1ns/1ns
`include "rx_link_consts.vh"

module rx_fifo #(
  parameter WIDTH = `FIFO_WIDTH,
  parameter DEPTH = `FIFO_DEPTH,
  parameter AW    = 4
) (
  input  wire             mclk,
  input  wire             resetn,
  input  wire             flush,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      fill;
  wire            do_wr;
  wire            do_rd;

  assign in_ready  = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  // storage has no reset; only pointers matter
  always @(posedge mclk) begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end

  // pointers wrap naturally since depth is a power of two
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else if (flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill   <= {(AW+1){1'b0}};
    end else begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
      if (do_wr && !do_rd)
        fill <= fill + 1'b1;
      else if (do_rd && !do_wr)
        fill <= fill - 1'b1;
    end
  end
endmodule // rx_fifo

module rx_link_init #(
  parameter FRAME_LEN = `DEFAULT_FRAME_LEN,
  parameter CFG_BYTES = 14
) (
  input  wire       mclk,
  input  wire       resetn,
  input  wire [7:0] phy_rx_char,
  input  wire       phy_rx_char_valid,
  input  wire       phy_rx_control_flag,
  input  wire       phy_rx_code_error,
  input  wire       phy_rx_disparity_error,
  input  wire       cdr_locked,
  input  wire       phy_cal_busy,
  input  wire       phy_analog_reset,
  input  wire       phy_digital_reset,
  input  wire       subclass1,
  input  wire       sysref,
  input  wire       transport_rx_ready,
  output reg        sync_request_n,
  output reg        dev_lane_aligned,
  output reg        alldev_lane_aligned,
  output reg        start_of_multiframe,
  output reg  [7:0] transport_rx_samples,
  output reg        transport_rx_valid,
  output reg        rx_link_interrupt,
  output reg        link_error,
  output reg  [1:0] link_phase,
  output reg  [7:0] cfg_byte,
  output reg  [3:0] cfg_index,
  output reg        cfg_valid,
  output reg        sysref_seen
);
  localparam PH_CGS  = 2'h0;
  localparam PH_WAIT = 2'h1;
  localparam PH_ILAS = 2'h2;
  localparam PH_DATA = 2'h3;

  // pin inputs pass two flops; first stage is read only by the second
  reg  [3:0] pin_meta;
  reg  [3:0] pin_sync;
  reg  [2:0] k_count;
  reg  [1:0] phase;
  reg  [2:0] mf_num;
  reg  [7:0] frame_pos;
  reg  [3:0] cfg_cnt;
  reg        sysref_d;
  wire       cdr_ok;
  wire       cal_busy_s;
  wire       sysref_s;
  wire       sub1_s;
  wire       link_ready;
  wire       char_ok;
  wire       is_k;
  wire       is_r;
  wire       mf_end;
  wire       fifo_in_ready;
  wire [7:0] fifo_data;
  wire       fifo_valid;
  wire       fifo_take;

  function is_ctrl;
    input [7:0] c;
    input [7:0] code;
    input       ctl;
    begin
      is_ctrl = ctl && (c == code);
    end
  endfunction

  // double-flop the pin-level status lines
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end else begin
      pin_meta <= {sysref, subclass1, phy_cal_busy, cdr_locked};
      pin_sync <= pin_meta;
    end
  end

  assign cdr_ok     = pin_sync[0];
  assign cal_busy_s = pin_sync[1];
  assign sub1_s     = pin_sync[2];
  assign sysref_s   = pin_sync[3];
  // phy resets are driven from the link clock domain, so read directly
  assign link_ready = cdr_ok && !cal_busy_s && !phy_analog_reset && !phy_digital_reset;
  assign char_ok    = phy_rx_char_valid && !phy_rx_code_error && !phy_rx_disparity_error;
  assign is_k       = char_ok && is_ctrl(phy_rx_char, `CHAR_K, phy_rx_control_flag);
  assign is_r       = char_ok && is_ctrl(phy_rx_char, `CHAR_R, phy_rx_control_flag);
  assign mf_end     = (frame_pos == FRAME_LEN[7:0] - 8'h01);
  assign fifo_take  = fifo_valid && transport_rx_ready;

  // link phase machine and counters
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      phase     <= PH_CGS;
      k_count   <= 3'h0;
      mf_num    <= 3'h0;
      frame_pos <= 8'h00;
      cfg_cnt   <= 4'h0;
    end else if (!link_ready) begin
      phase   <= PH_CGS; // lost lock drops the link back to sync
      k_count <= 3'h0;
    end else if (phy_rx_char_valid) begin
      case (phase)
        PH_CGS: begin
          if (!is_k)
            k_count <= 3'h0;
          else if (k_count == `K_COUNT_NEEDED - 3'h1)
            phase <= PH_WAIT;
          else
            k_count <= k_count + 3'h1;
        end
        PH_WAIT: begin
          if (is_r) begin
            phase     <= PH_ILAS;
            mf_num    <= 3'h1;
            frame_pos <= 8'h01;
            cfg_cnt   <= 4'h0;
          end else if (!is_k) begin
            phase   <= PH_CGS;
            k_count <= 3'h0;
          end
        end
        PH_ILAS: begin
          frame_pos <= mf_end ? 8'h00 : frame_pos + 8'h01;
          if (mf_num == `CFG_MULTIFRAME && frame_pos >= 8'h02 && cfg_cnt != CFG_BYTES[3:0])
            cfg_cnt <= cfg_cnt + 4'h1;
          if (mf_end) begin
            if (mf_num == `ILAS_MULTIFRAMES)
              phase <= PH_DATA;
            else
              mf_num <= mf_num + 3'h1;
          end
        end
        PH_DATA: begin
          frame_pos <= mf_end ? 8'h00 : frame_pos + 8'h01;
          if (!char_ok) begin
            phase   <= PH_CGS; // a bad character forces resync
            k_count <= 3'h0;
          end
        end
        default: phase <= PH_CGS;
      endcase
    end
  end

  // registered outputs; sync request and alignment are all on mclk
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync_request_n      <= 1'b0;
      dev_lane_aligned    <= 1'b0;
      alldev_lane_aligned <= 1'b0;
      start_of_multiframe <= 1'b0;
      link_phase          <= PH_CGS;
      cfg_byte            <= 8'h00;
      cfg_index           <= 4'h0;
      cfg_valid           <= 1'b0;
      link_error          <= 1'b0;
      rx_link_interrupt   <= 1'b0;
      sysref_d            <= 1'b0;
      sysref_seen         <= 1'b0;
    end else begin
      sync_request_n      <= (phase != PH_CGS);
      dev_lane_aligned    <= (phase == PH_DATA);
      alldev_lane_aligned <= (phase == PH_DATA);
      start_of_multiframe <= (phase == PH_ILAS || phase == PH_DATA) && phy_rx_char_valid && frame_pos == 8'h00;
      link_phase          <= phase;
      cfg_valid           <= link_ready && phy_rx_char_valid && phase == PH_ILAS &&
                             mf_num == `CFG_MULTIFRAME && frame_pos >= 8'h02 && cfg_cnt != CFG_BYTES[3:0];
      cfg_byte            <= phy_rx_char;
      cfg_index           <= cfg_cnt;
      link_error          <= phy_rx_char_valid && !char_ok;
      rx_link_interrupt   <= (phase == PH_DATA) && phy_rx_char_valid && !char_ok;
      sysref_d            <= sysref_s;
      // sysref ignored unless subclass 1 is selected
      if (sub1_s && sysref_s && !sysref_d)
        sysref_seen <= 1'b1;
      else if (!sub1_s)
        sysref_seen <= 1'b0;
    end
  end

  // user data buffered so the transport layer may stall briefly
  rx_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .flush     (phase != PH_DATA),
    .in_data   (phy_rx_char),
    .in_valid  (phase == PH_DATA && char_ok),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (transport_rx_ready)
  );

  // output stage; lane data has no back-pressure, overflow drops words
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      transport_rx_samples <= 8'h00;
      transport_rx_valid   <= 1'b0;
    end else begin
      transport_rx_valid <= fifo_take;
      if (fifo_take)
        transport_rx_samples <= fifo_data;
    end
  end

  wire unused_ok = fifo_in_ready;
endmodule // rx_link_init

// ### verif/rx_link_chk.sv
/*
  checker for the receive link block, watching its pins only.
  assumes the single mclk domain and the async active-low reset.
*/
`timescale 1ns/1ns
module rx_link_chk (
  input wire       mclk,
  input wire       resetn,
  input wire       cdr_locked,
  input wire       phy_analog_reset,
  input wire       subclass1,
  input wire       sync_request_n,
  input wire       dev_lane_aligned,
  input wire       alldev_lane_aligned,
  input wire       rx_link_interrupt,
  input wire       link_error,
  input wire [1:0] link_phase,
  input wire [3:0] cfg_index,
  input wire       cfg_valid,
  input wire       sysref_seen,
  input wire       start_of_multiframe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // flags and phase relations; lock needs five samples to cover the synchroniser
  a_aligned_pair: assert property (dev_lane_aligned == alldev_lane_aligned)
    else $error("aligned flags differ");
  a_aligned_data: assert property ($rose(dev_lane_aligned) |-> link_phase == 2'd3)
    else $error("aligned outside data phase");
  a_sync_release: assert property ($rose(sync_request_n) |-> link_phase == 2'd1)
    else $error("sync released without k count");
  a_ilas_sync: assert property (link_phase == 2'd2 |-> sync_request_n)
    else $error("sync low during alignment");
  a_unlock_cgs: assert property ((!cdr_locked) [*5] |-> link_phase == 2'd0)
    else $error("phase left sync while unlocked");
  a_reset_cgs: assert property (phy_analog_reset [*3] |-> link_phase == 2'd0)
    else $error("phase left sync in phy reset");
  a_irq_err: assert property (rx_link_interrupt |-> link_error)
    else $error("interrupt without link error");
  a_cfg_window: assert property (cfg_valid |-> link_phase == 2'd2 && cfg_index <= 4'd13)
    else $error("config byte outside alignment");
  a_sysref_off: assert property ((!subclass1) [*4] |-> !sysref_seen)
    else $error("sysref used outside subclass 1");
  a_somf_phase: assert property (start_of_multiframe |-> link_phase[1])
    else $error("multiframe start outside alignment or data");

  // main scenarios
  c_sync: cover property ($rose(sync_request_n));
  c_align: cover property ($rose(dev_lane_aligned));
  c_irq: cover property (rx_link_interrupt);
  c_cfg: cover property (cfg_valid && cfg_index == 4'd13);
endmodule // rx_link_chk

bind rx_link_init rx_link_chk u_chk (.mclk, .resetn, .cdr_locked, .phy_analog_reset, .subclass1, .sync_request_n,
  .dev_lane_aligned, .alldev_lane_aligned, .rx_link_interrupt, .link_error, .link_phase, .cfg_index, .cfg_valid,
  .sysref_seen, .start_of_multiframe);

// ### verif/adc_model.sv
/*
  converter model: K while sync is requested, two more K, then an alignment
  sequence of four multiframes and a ramp. assumes FL of at least 17.
*/
`timescale 1ns/1ns
`include "rx_link_consts.vh"
module adc_model #(
  parameter FL = 32
) (
  input  wire       mclk,
  input  wire       resetn,
  input  wire       sync_request_n,
  input  wire       corrupt,
  output reg  [7:0] ch,
  output reg        ctl,
  output reg        err
);
  reg [8:0] n;
  reg [7:0] ramp;

  // one character per cycle; ILAS byte i carries i so config bytes are predictable
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      n    <= 9'h000;
      ramp <= 8'h00;
      ch   <= `CHAR_K;
      ctl  <= 1'b1;
      err  <= 1'b0;
    end else begin
      err <= corrupt;
      if (!sync_request_n) begin
        n    <= 9'h000;
        ramp <= 8'h00;
        ch   <= `CHAR_K;
        ctl  <= 1'b1;
      end else if (n < 9'h002) begin
        n <= n + 9'h001;
      end else if (n < 9'h002 + 4 * FL) begin
        n   <= n + 9'h001;
        ch  <= (n == 9'h002) ? `CHAR_R : ((n - 2) % FL == FL - 1) ? `CHAR_A : n[7:0] - 8'h02;
        ctl <= (n == 9'h002) || ((n - 2) % FL == FL - 1);
      end else begin
        ch   <= ramp;
        ctl  <= 1'b0;
        ramp <= ramp + 8'h01;
      end
    end
  end
endmodule // adc_model

// ### verif/testbench.sv
/*
  testbench for the receive link block against the converter model.
  assumes the design, the checker and the model are compiled first.
*/
`timescale 1ns/1ns
`include "rx_link_consts.vh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", nm, e, g); error_cnt++; end end
module testbench;
  localparam FL = 32;
  reg         mclk = 1'b0, resetn = 1'b0, corrupt = 1'b0, sel = 1'b0, sc1 = 1'b0, sysref = 1'b0, ready = 1'b1;
  reg  [3:0]  blk = 4'h1; // unlock, cal busy, analog reset, digital reset
  reg  [31:0] seed = 32'h943ec272;
  reg  [31:0] r;
  reg  [7:0]  exp_word = 8'h00;
  reg  [3:0]  exp_idx = 4'h0;
  int         error_cnt = 0, comparisons = 0, cycles = 0, words = 0;
  wire [7:0]  ch, samples, cfg_b;
  wire [3:0]  cfg_i;
  wire [1:0]  phase;
  wire        ctl, err, sync_n, all_al, irq, cfg_v, sref, s_valid;

  always #10 mclk = ~mclk;
  adc_model #(.FL(FL)) u_adc (.mclk(mclk), .resetn(resetn), .sync_request_n(sync_n), .corrupt(corrupt), .ch(ch),
    .ctl(ctl), .err(err));
  rx_link_init #(.FRAME_LEN(FL)) DUT (.mclk(mclk), .resetn(resetn), .phy_rx_char(ch), .phy_rx_char_valid(1'b1),
    .phy_rx_control_flag(ctl), .phy_rx_code_error(err & sel), .phy_rx_disparity_error(err & ~sel),
    .cdr_locked(~blk[0]), .phy_cal_busy(blk[1]), .phy_analog_reset(blk[2]), .phy_digital_reset(blk[3]),
    .subclass1(sc1), .sysref(sysref), .transport_rx_ready(ready), .sync_request_n(sync_n), .dev_lane_aligned(),
    .alldev_lane_aligned(all_al), .start_of_multiframe(), .transport_rx_samples(samples),
    .transport_rx_valid(s_valid), .rx_link_interrupt(irq), .link_error(), .link_phase(phase), .cfg_byte(cfg_b),
    .cfg_index(cfg_i), .cfg_valid(cfg_v), .sysref_seen(sref));

  function [31:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd  = seed;
    end
  endfunction

  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // watchdog, then ramp and config monitors; old values are read at the edge
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      give_verdict;
    end
    if (phase !== 2'd3) exp_word <= 8'h00;
    else if (s_valid === 1'b1) begin
      `CHK("samples", exp_word, samples)
      exp_word <= exp_word + 8'h01;
      words++;
    end
    if (phase === 2'd0) exp_idx <= 4'h0;
    else if (cfg_v === 1'b1) begin
      `CHK("cfg_index", exp_idx, cfg_i)
      `CHK("cfg_byte", exp_idx + FL + 2, cfg_b)
      exp_idx <= exp_idx + 4'h1;
    end
  end

  initial begin
    int i, j, seen, back;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    #1 `CHK("sync_reset", 1'b0, sync_n)
    // each blocker alone must hold the link in sync request
    for (i = 0; i < 4; i++) begin
      @(posedge mclk);
      blk <= 4'h1 << i;
      repeat (30) @(posedge mclk);
      #1 `CHK("sync_blocked", 1'b0, sync_n)
    end
    $display("test blockers done");
    // every third K flagged bad, with a random error kind: count never reaches four
    @(posedge mclk);
    blk <= 4'h0;
    for (i = 0; i < 45; i++) begin
      @(posedge mclk);
      r = rnd();
      corrupt <= (i % 3 == 0); // bad char lands before a fourth good K can
      sel <= r[0];
    end
    #1 `CHK("sync_bad_k", 1'b0, sync_n)
    $display("test k restart done");
    @(posedge mclk);
    corrupt <= 1'b0;
    for (i = 0; i < 600 && phase !== 2'd3; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    #1 `CHK("phase_data", 2'd3, phase)
    `CHK("all_aligned", 1'b1, all_al)
    `CHK("cfg_count", 4'd14, exp_idx)
    // stall the consumer for a random time short of the fifo depth
    repeat (20) @(posedge mclk);
    r = rnd();
    ready <= 1'b0;
    repeat (1 + r[3:0] % 12) @(posedge mclk);
    ready <= 1'b1;
    repeat (40) @(posedge mclk);
    #1 `CHK("words_seen", 1'b1, words > 40)
    $display("test stream done");
    @(posedge mclk);
    corrupt <= 1'b1;
    @(posedge mclk);
    corrupt <= 1'b0;
    seen = 0;
    back = 0;
    for (i = 0; i < 10; i++) begin
      @(posedge mclk);
      if (irq === 1'b1) seen = 1;
      if (seen == 1 && phase === 2'd0) back = 1; // resync restarts quickly, so catch it in passing
    end
    #1 `CHK("irq_seen", 1, seen)
    `CHK("phase_back", 1, back)
    $display("test data error done");
    // a sysref pulse counts only in subclass 1
    for (j = 0; j < 2; j++) begin
      @(posedge mclk);
      sc1 <= j[0];
      repeat (5) @(posedge mclk);
      sysref <= 1'b1;
      repeat (3) @(posedge mclk);
      sysref <= 1'b0;
      repeat (6) @(posedge mclk);
      #1 `CHK("sysref_seen", j[0], sref)
    end
    $display("test sysref done");
    give_verdict;
  end
endmodule // testbench
